// *** shared/ard_pkg.sv ***
// Constants, types and register map of the acquisition record decimator
`default_nettype none

package ard_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ARD_OFF_CTRL     = 8'h00;
  localparam logic [7:0] ARD_OFF_SPAN     = 8'h04;
  localparam logic [7:0] ARD_OFF_POINTS   = 8'h08;
  localparam logic [7:0] ARD_OFF_TDIV     = 8'h0c;
  localparam logic [7:0] ARD_OFF_TARGET   = 8'h10;
  localparam logic [7:0] ARD_OFF_STATUS   = 8'h14;
  localparam logic [7:0] ARD_OFF_INFO     = 8'h18;
  localparam logic [7:0] ARD_OFF_INTERVAL = 8'h1c;

  localparam logic [31:0] ARD_CTRL_MASK    = 32'h0000_037f;
  localparam logic [31:0] ARD_CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] ARD_SPAN_RST     = 32'h0000_1388;
  localparam logic [15:0] ARD_POINTS_RST   = 16'h01f4;
  localparam logic [31:0] ARD_TDIV_RST     = 32'h0000_01f4;
  localparam logic [15:0] ARD_TARGET_RST   = 16'h0010;
  localparam logic [31:0] ARD_INTERVAL_RST = (ARD_SPAN_RST * 32'd2) / {16'h0, ARD_POINTS_RST};

  // ----------------------------------------------------------------
  // Timing and resolution
  // ----------------------------------------------------------------
  localparam int ARD_BASE_PERIOD_NS   = 1;
  localparam int ARD_HNS_PER_NS       = 2;
  localparam int ARD_RATE_PER_DIG_MSPS = 500;
  localparam int ARD_MEAN_GAIN_TDIV_NS = 100;
  localparam int ARD_BASE_BITS        = 8;
  localparam int ARD_MAX_BITS         = 15;
  localparam logic [3:0] ARD_MAX_EXT  = 4'(ARD_MAX_BITS - ARD_BASE_BITS);
  // Sample spacing in half-ns for 4, 2 and 1 digitizers per channel
  localparam logic [2:0] ARD_SPACING_DIG4 = 3'h1;
  localparam logic [2:0] ARD_SPACING_DIG2 = 3'h2;
  localparam logic [2:0] ARD_SPACING_DIG1 = 3'h4;
  localparam logic [31:0] ARD_BASE_PERIOD_HNS = 32'(ARD_BASE_PERIOD_NS * ARD_HNS_PER_NS);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ARD_MODE_SAMPLE   = 3'h0,
    ARD_MODE_PEAK     = 3'h1,
    ARD_MODE_MEAN     = 3'h2,
    ARD_MODE_ENVELOPE = 3'h3,
    ARD_MODE_AVERAGE  = 3'h4
  } ard_mode_t;

  typedef enum logic [7:0] {
    ARD_ST_IDLE   = 8'h01,
    ARD_ST_SETUP  = 8'h02,
    ARD_ST_ARM    = 8'h04,
    ARD_ST_ACQ    = 8'h08,
    ARD_ST_INTERP = 8'h10,
    ARD_ST_DIV    = 8'h20,
    ARD_ST_DONE   = 8'h40
  } ard_state_t;

  typedef struct packed {
    logic [21:0] rsvd_hi;
    logic [1:0]  chans_m1;
    logic        rsvd_lo;
    ard_mode_t   mode;
    logic        et_en;
    logic        curve_fit;
    logic        single_seq;
    logic        run;
  } ard_ctrl_t;

  typedef struct packed {
    logic        last;
    logic        interp;
    logic [15:0] index;
    logic [15:0] value;
  } ard_point_t;

endpackage

`default_nettype wire

// *** rtl/ard_decimator.sv ***
// Record point builder with AHB-Lite register slave
`default_nettype none

module ard_decimator
  import ard_pkg::*;
#(
  parameter int REC_DEPTH = 500
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        trig,
  input  wire logic        sample_valid,
  input  wire logic [7:0]  sample_data,
  output logic             sample_ready,
  output logic             rec_valid,
  output ard_point_t       rec_point
);

  localparam int IDX_W = $clog2(REC_DEPTH);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  ard_ctrl_t   ctrl_reg;
  logic [31:0] span_reg;
  logic [15:0] points_reg;
  logic [31:0] tdiv_reg;
  logic [15:0] target_reg;
  logic        dp_write_reg;
  logic [7:0]  dp_addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_val;
  logic [31:0] status_val;
  logic [31:0] info_val;
  logic [31:0] interval_reg;

  wire       addr_take = hsel && htrans[1] && hready;
  wire [7:0] a_addr    = haddr[7:0];
  wire       wr_ctrl   = dp_write_reg && (dp_addr_reg == ARD_OFF_CTRL);
  wire       wr_span   = dp_write_reg && (dp_addr_reg == ARD_OFF_SPAN);
  wire       wr_points = dp_write_reg && (dp_addr_reg == ARD_OFF_POINTS);
  wire       wr_tdiv   = dp_write_reg && (dp_addr_reg == ARD_OFF_TDIV);
  wire       wr_target = dp_write_reg && (dp_addr_reg == ARD_OFF_TARGET);
  wire ard_ctrl_t ctrl_wd = ard_ctrl_t'(hwdata & ARD_CTRL_MASK);
  wire [15:0] points_wd = (hwdata[15:0] == 16'h0) ? 16'h1 :
                          (hwdata[15:0] > 16'(REC_DEPTH)) ? 16'(REC_DEPTH) : hwdata[15:0];
  wire [15:0] target_wd = (hwdata[15:0] == 16'h0) ? 16'h1 : hwdata[15:0];
  wire restart = (wr_ctrl && ctrl_wd.run) || wr_span || wr_points || wr_tdiv || wr_target;
  wire stop_sw = wr_ctrl && !ctrl_wd.run;

  assign rd_val = (a_addr == ARD_OFF_CTRL)     ? 32'(ctrl_reg) :
                  (a_addr == ARD_OFF_SPAN)     ? span_reg :
                  (a_addr == ARD_OFF_POINTS)   ? {16'h0, points_reg} :
                  (a_addr == ARD_OFF_TDIV)     ? tdiv_reg :
                  (a_addr == ARD_OFF_TARGET)   ? {16'h0, target_reg} :
                  (a_addr == ARD_OFF_STATUS)   ? status_val :
                  (a_addr == ARD_OFF_INFO)     ? info_val :
                  (a_addr == ARD_OFF_INTERVAL) ? interval_reg : 32'h0;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
      hrdata_reg   <= 32'h0;
    end else begin
      dp_write_reg <= addr_take && hwrite;
      if (addr_take) begin
        dp_addr_reg <= a_addr;
      end
      if (addr_take && !hwrite) begin
        hrdata_reg <= rd_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Derived acquisition settings
  // ----------------------------------------------------------------
  ard_state_t  state_reg;
  logic [2:0]  digs;
  logic [2:0]  spacing;
  logic [15:0] acq_cnt_reg;
  logic [3:0]  msb_idx;

  assign digs    = (ctrl_reg.chans_m1 == 2'h0) ? 3'h4 : (ctrl_reg.chans_m1 == 2'h1) ? 3'h2 : 3'h1;
  assign spacing = (digs == 3'h4) ? ARD_SPACING_DIG4 : (digs == 3'h2) ? ARD_SPACING_DIG2 : ARD_SPACING_DIG1;
  wire [15:0] rate_msps = 16'(ARD_RATE_PER_DIG_MSPS) * {13'h0, digs};

  wire        need_more = interval_reg < {29'h0, spacing};
  wire        interp_on = need_more && !ctrl_reg.et_en;
  wire        et_on     = need_more && ctrl_reg.et_en;
  // Counted against the base sampling period, whatever the interleave
  wire [31:0] spi_full  = interval_reg / ARD_BASE_PERIOD_HNS;
  wire [15:0] spi       = (spi_full == 32'h0) ? 16'h1 :
                          (spi_full > 32'h0000_ffff) ? 16'hffff : spi_full[15:0];
  wire [2:0]  ivl_nz    = (interval_reg == 32'h0) ? 3'h1 : interval_reg[2:0];
  wire [2:0]  ratio_raw = spacing / ivl_nz;
  wire [2:0]  ratio     = (ratio_raw < 3'h2) ? 3'h2 : ratio_raw;
  wire ard_mode_t emode = (need_more && (ctrl_reg.mode == ARD_MODE_PEAK || ctrl_reg.mode == ARD_MODE_MEAN))
                          ? ARD_MODE_SAMPLE : ctrl_reg.mode;

  // Highest set bit of the interval sample count
  always_comb begin
    msb_idx = 4'h0;
    for (int b = 0; b < 16; b++) begin
      if (spi[b]) begin
        msb_idx = 4'(b);
      end
    end
  end

  wire [3:0] ext_raw = {1'b0, msb_idx[3:1]};
  wire [3:0] ext = (tdiv_reg <= 32'(ARD_MEAN_GAIN_TDIV_NS)) ? 4'h0 :
                   (ext_raw > ARD_MAX_EXT) ? ARD_MAX_EXT : ext_raw;
  wire [3:0] res_bits = 4'(ARD_BASE_BITS) + ext;

  assign status_val = {(ctrl_reg.run ? rate_msps : acq_cnt_reg), 10'h0, et_on, interp_on, emode,
                       ctrl_reg.run};
  assign info_val   = {5'h0, ratio, 1'b0, digs, res_bits, spi};

  // ----------------------------------------------------------------
  // Sequential divider
  // ----------------------------------------------------------------
  logic [31:0] dv_num_reg;
  logic [31:0] dv_den_reg;
  logic [31:0] dv_rem_reg;
  logic [5:0]  dv_cnt_reg;
  logic        dv_busy_reg;
  logic        dv_go;
  logic [31:0] dv_num_in;
  logic [31:0] dv_den_in;

  wire [32:0] dv_shift = {dv_rem_reg, dv_num_reg[31]};
  wire        dv_ge    = dv_shift >= {1'b0, dv_den_reg};
  wire [32:0] dv_diff  = dv_shift - {1'b0, dv_den_reg};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dv_num_reg  <= 32'h0;
      dv_den_reg  <= 32'h1;
      dv_rem_reg  <= 32'h0;
      dv_cnt_reg  <= 6'h0;
      dv_busy_reg <= 1'b0;
    end else if (dv_go) begin
      dv_num_reg  <= dv_num_in;
      dv_den_reg  <= dv_den_in;
      dv_rem_reg  <= 32'h0;
      dv_cnt_reg  <= 6'h20;
      dv_busy_reg <= 1'b1;
    end else if (dv_busy_reg) begin
      dv_rem_reg  <= dv_ge ? dv_diff[31:0] : dv_shift[31:0];
      dv_num_reg  <= {dv_num_reg[30:0], dv_ge};
      dv_cnt_reg  <= dv_cnt_reg - 6'h1;
      dv_busy_reg <= (dv_cnt_reg != 6'h1);
    end
  end

  // ----------------------------------------------------------------
  // Point store for envelope and average
  // ----------------------------------------------------------------
  logic [31:0] mem [REC_DEPTH];
  logic [15:0] pt_idx_reg;
  logic        mem_we;
  logic [31:0] mem_wd;

  for (genvar i = 0; i < REC_DEPTH; i++) begin : g_mem
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        mem[i] <= 32'h0;
      end else if (restart) begin
        mem[i] <= 32'h0;
      end else if (mem_we && pt_idx_reg[IDX_W-1:0] == IDX_W'(i)) begin
        mem[i] <= mem_wd;
      end
    end
  end

  // ----------------------------------------------------------------
  // Decimation and interpolation datapath
  // ----------------------------------------------------------------
  logic [15:0] cnt_reg;
  logic [7:0]  cap_reg;
  logic [7:0]  mx_reg;
  logic [7:0]  mn_reg;
  logic [23:0] sum_reg;
  logic [7:0]  prev1_reg;
  logic [7:0]  prev2_reg;
  logic [7:0]  cur_reg;
  logic        have_prev_reg;
  logic [2:0]  k_reg;
  logic [15:0] set_cnt_reg;
  logic        div_setup_reg;
  ard_state_t  ret_state_reg;
  logic [17:0] pend_reg;
  logic        rec_valid_reg;
  ard_point_t  rec_point_reg;

  wire       take     = sample_valid && sample_ready;
  wire       first_in = (cnt_reg == 16'h0);
  wire       last_in  = (cnt_reg == spi - 16'h1);
  wire [7:0] nmax = (first_in || sample_data > mx_reg) ? sample_data : mx_reg;
  wire [7:0] nmin = (first_in || sample_data < mn_reg) ? sample_data : mn_reg;
  wire [7:0] ncap = first_in ? sample_data : cap_reg;
  wire [23:0] nsum = first_in ? {16'h0, sample_data} : sum_reg + {16'h0, sample_data};

  // Interpolated value between prev1 and cur at fraction k/ratio
  wire [8:0] t_q8 = 9'(({9'h0, k_reg} * 12'd256) / {9'h0, ratio});
  wire signed [31:0] ts  = $signed({23'h0, t_q8});
  wire signed [31:0] p0  = $signed({24'h0, prev2_reg});
  wire signed [31:0] p1  = $signed({24'h0, prev1_reg});
  wire signed [31:0] p2  = $signed({24'h0, cur_reg});
  wire signed [31:0] lin = p1 + ((ts * (p2 - p1)) >>> 8);
  wire signed [31:0] crv = p1 + ((ts * (p2 - p0)) >>> 9)
                           + ((ts * ts * (p2 - (p1 <<< 1) + p0)) >>> 17);
  wire signed [31:0] iv_s = ctrl_reg.curve_fit ? crv : lin;
  wire [7:0] iv = (iv_s < 0) ? 8'h00 : (iv_s > 32'sd255) ? 8'hff : iv_s[7:0];

  wire in_interp = (state_reg == ARD_ST_INTERP);
  wire fire = (state_reg == ARD_ST_ACQ && take && !interp_on && last_in) || in_interp;
  wire pt_last = (pt_idx_reg == points_reg - 16'h1);
  wire [7:0] raw = in_interp ? iv :
                   (emode == ARD_MODE_PEAK || emode == ARD_MODE_ENVELOPE) ? (pt_idx_reg[0] ? nmin : nmax)
                   : ncap;
  wire [31:0] mem_rd    = mem[pt_idx_reg[IDX_W-1:0]];
  wire        first_set = (set_cnt_reg == 16'h0);
  wire [7:0]  env_val = first_set ? raw :
                        pt_idx_reg[0] ? ((raw < mem_rd[7:0]) ? raw : mem_rd[7:0]) :
                                        ((raw > mem_rd[7:0]) ? raw : mem_rd[7:0]);
  wire [31:0] avg_sum  = (first_set ? 32'h0 : mem_rd) + {24'h0, raw};
  wire        is_env   = (emode == ARD_MODE_ENVELOPE);
  wire        is_avg   = (emode == ARD_MODE_AVERAGE);
  wire        need_div = is_avg || (emode == ARD_MODE_MEAN);
  wire [31:0] mean_num = {8'h0, nsum} << ext;
  wire        pt_interp = in_interp && (k_reg != ratio);
  wire [17:0] fire_tag  = {pt_last, pt_interp, pt_idx_reg};
  wire        emit_direct = fire && !need_div;
  wire        div_emit = (state_reg == ARD_ST_DIV) && !dv_busy_reg && !div_setup_reg;
  wire ard_state_t after = pt_last ? ARD_ST_DONE : pt_interp ? ARD_ST_INTERP : ARD_ST_ACQ;
  wire        multi    = (ctrl_reg.mode == ARD_MODE_ENVELOPE) || (ctrl_reg.mode == ARD_MODE_AVERAGE);
  wire        set_done = !multi || (set_cnt_reg + 16'h1 >= target_reg);
  wire        stop_hw  = (state_reg == ARD_ST_DONE) && ctrl_reg.single_seq && set_done;

  assign mem_we    = fire && (is_env || is_avg);
  assign mem_wd    = is_env ? {24'h0, env_val} : avg_sum;
  assign dv_go     = (state_reg == ARD_ST_SETUP) || (fire && need_div);
  assign dv_num_in = (state_reg == ARD_ST_SETUP) ? (span_reg * ARD_HNS_PER_NS) / ARD_BASE_PERIOD_HNS * ARD_BASE_PERIOD_HNS :
                     is_avg ? avg_sum : mean_num;
  assign dv_den_in = (state_reg == ARD_ST_SETUP) ? {16'h0, points_reg} :
                     is_avg ? {16'h0, set_cnt_reg} + 32'h1 : {16'h0, spi};

  assign sample_ready = (state_reg == ARD_ST_ACQ);
  assign rec_valid    = rec_valid_reg;
  assign rec_point    = rec_point_reg;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg   <= ard_ctrl_t'(ARD_CTRL_RST);
      span_reg   <= ARD_SPAN_RST;
      points_reg <= ARD_POINTS_RST;
      tdiv_reg   <= ARD_TDIV_RST;
      target_reg <= ARD_TARGET_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= ctrl_wd;
      end else if (stop_hw) begin
        ctrl_reg.run <= 1'b0;
      end
      if (wr_span)   span_reg   <= hwdata;
      if (wr_points) points_reg <= points_wd;
      if (wr_tdiv)   tdiv_reg   <= hwdata;
      if (wr_target) target_reg <= target_wd;
    end
  end

  // ----------------------------------------------------------------
  // Acquisition sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg     <= ARD_ST_IDLE;
      ret_state_reg <= ARD_ST_IDLE;
      interval_reg  <= ARD_INTERVAL_RST;
      div_setup_reg <= 1'b0;
      pt_idx_reg    <= 16'h0;
      cnt_reg       <= 16'h0;
      cap_reg       <= 8'h00;
      mx_reg        <= 8'h00;
      mn_reg        <= 8'h00;
      sum_reg       <= 24'h0;
      prev1_reg     <= 8'h00;
      prev2_reg     <= 8'h00;
      cur_reg       <= 8'h00;
      have_prev_reg <= 1'b0;
      k_reg         <= 3'h1;
      set_cnt_reg   <= 16'h0;
      acq_cnt_reg   <= 16'h0;
      pend_reg      <= 18'h0;
    end else if (restart) begin
      state_reg   <= ARD_ST_SETUP;
      set_cnt_reg <= 16'h0;
      acq_cnt_reg <= 16'h0;
    end else if (stop_sw) begin
      state_reg <= ARD_ST_IDLE;
    end else begin
      case (state_reg)
        ARD_ST_SETUP: begin
          div_setup_reg <= 1'b1;
          ret_state_reg <= ctrl_reg.run ? ARD_ST_ARM : ARD_ST_IDLE;
          state_reg     <= ARD_ST_DIV;
        end
        ARD_ST_ARM: begin
          if (trig) begin
            state_reg     <= ARD_ST_ACQ;
            pt_idx_reg    <= 16'h0;
            cnt_reg       <= 16'h0;
            have_prev_reg <= 1'b0;
          end
        end
        ARD_ST_ACQ: begin
          if (take && interp_on) begin
            cur_reg   <= sample_data;
            k_reg     <= 3'h1;
            state_reg <= ARD_ST_INTERP;
            if (!have_prev_reg) begin
              prev1_reg     <= sample_data;
              prev2_reg     <= sample_data;
              have_prev_reg <= 1'b1;
            end
          end else if (take) begin
            cnt_reg <= last_in ? 16'h0 : cnt_reg + 16'h1;
            cap_reg <= ncap;
            mx_reg  <= nmax;
            mn_reg  <= nmin;
            sum_reg <= nsum;
          end
        end
        ARD_ST_INTERP: begin
          k_reg <= k_reg + 3'h1;
          if (k_reg == ratio) begin
            prev2_reg <= prev1_reg;
            prev1_reg <= cur_reg;
          end
        end
        ARD_ST_DIV: begin
          if (!dv_busy_reg) begin
            if (div_setup_reg) begin
              interval_reg <= dv_num_reg;
            end
            div_setup_reg <= 1'b0;
            state_reg     <= ret_state_reg;
          end
        end
        ARD_ST_DONE: begin
          acq_cnt_reg <= acq_cnt_reg + 16'h1;
          if (multi) begin
            set_cnt_reg <= set_done ? 16'h0 : set_cnt_reg + 16'h1;
          end
          state_reg <= stop_hw ? ARD_ST_IDLE : ARD_ST_ARM;
        end
        default: begin
          state_reg <= state_reg;
        end
      endcase
      if (fire) begin
        pt_idx_reg    <= pt_idx_reg + 16'h1;
        pend_reg      <= fire_tag;
        ret_state_reg <= after;
        state_reg     <= need_div ? ARD_ST_DIV : after;
      end
    end
  end

  // ----------------------------------------------------------------
  // Record point output
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rec_valid_reg <= 1'b0;
      rec_point_reg <= '0;
    end else begin
      rec_valid_reg <= emit_direct || div_emit;
      if (emit_direct) begin
        rec_point_reg <= {fire_tag, 8'h00, (is_env ? env_val : raw)};
      end else if (div_emit) begin
        rec_point_reg <= {pend_reg, dv_num_reg[15:0]};
      end
    end
  end

endmodule

`default_nettype wire

// *** dv/ard_assertions.sv ***
// Port checker for the record point builder
`default_nettype none
module ard_assertions
  import ard_pkg::*;
#(
  parameter int REC_DEPTH = 500
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        sample_ready,
  input wire logic        rec_valid,
  input wire ard_point_t  rec_point
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       rd_reg;
  logic [7:0] ra_reg;
  // Read data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_reg <= 1'b0;
      ra_reg <= 8'h00;
    end else begin
      rd_reg <= hsel && htrans[1] && hready && !hwrite;
      ra_reg <= haddr[7:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
  a_zero_wait: assert property (hreadyout == 1'b1) else $error("wait state");
  a_unmapped_zero: assert property (rd_reg && ra_reg >= 8'h20 |-> hrdata == 32'h0) else $error("unmapped data");
  a_ctrl_rsvd: assert property (rd_reg && ra_reg == ARD_OFF_CTRL |-> (hrdata & ~ARD_CTRL_MASK) == 32'h0)
    else $error("reserved bits set");
  a_width_cap: assert property (rec_valid |-> rec_point.value[15] == 1'b0) else $error("over 15 bits");
  a_interp_byte: assert property (rec_valid && rec_point.interp |-> rec_point.value[15:8] == 8'h00)
    else $error("wide interpolated point");
  a_index_range: assert property (rec_valid |-> rec_point.index < REC_DEPTH) else $error("index out of range");
  a_record_pause: assert property (rec_valid && rec_point.last |=> !sample_ready) else $error("no pause");
  c_last: cover property (rec_valid && rec_point.last);
  c_interp: cover property (rec_valid && rec_point.interp);
  c_unmapped: cover property (rd_reg && ra_reg >= 8'h20);
endmodule
bind ard_decimator ard_assertions #(.REC_DEPTH(REC_DEPTH)) chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .sample_ready, .rec_valid, .rec_point);
`default_nettype wire

// *** dv/ard_digitizer_model.sv ***
// Digitizer stream model: even-valued ramp, optional stalls
`default_nettype none
module ard_digitizer_model (
  input wire logic  clk,
  input wire logic  rstn,
  input wire logic  ready,
  input wire logic  rewind,
  input wire logic  slow,
  output logic      valid,
  output logic [7:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] cnt_reg;
  logic       ph_reg;
  // Offer held until taken; idle data is inverted
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 7'h00;
      ph_reg <= 1'b0;
    end else begin
      ph_reg <= (valid && !ready) ? ph_reg : ~ph_reg;
      cnt_reg <= rewind ? 7'h00 : cnt_reg + 7'(valid && ready);
    end
  end
  assign valid = rstn && (!slow || ph_reg);
  assign data = valid ? {cnt_reg, 1'b0} : ~{cnt_reg, 1'b0};
endmodule
`default_nettype wire

// *** dv/acquisition_record_decimator_bench.sv ***
// Self-checking bench for the record point builder
`default_nettype none
module acquisition_record_decimator_bench
  import ard_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, trig = 0, slow = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0] htrans = '0;
  logic hreadyout, hresp, sample_valid, sample_ready, rec_valid;
  wire logic hready = hreadyout;
  logic [7:0] sample_data;
  ard_point_t rec_point, pts [4];
  int err_count = 0, n_checks = 0;
  // Rows: mode, acquisitions, four expected points
  localparam logic [42:0] ROWS [5] = '{{3'h0, 8'd1, 32'h00_04_08_0c}, {3'h1, 8'd1, 32'h02_04_0a_0c},
    {3'h2, 8'd1, 32'h01_05_09_0d}, {3'h3, 8'd2, 32'h02_04_0a_0c}, {3'h4, 8'd2, 32'h00_04_08_0c}};
  localparam logic [39:0] RSTV [6] = '{{ARD_OFF_CTRL, ARD_CTRL_RST}, {ARD_OFF_SPAN, ARD_SPAN_RST},
    {ARD_OFF_POINTS, 16'h0, ARD_POINTS_RST}, {ARD_OFF_TDIV, ARD_TDIV_RST},
    {ARD_OFF_TARGET, 16'h0, ARD_TARGET_RST}, {ARD_OFF_INTERVAL, ARD_INTERVAL_RST}};
  always #20 hclk = ~hclk;
  always @(posedge hclk) if (rec_valid === 1'b1) pts[rec_point.index[1:0]] <= rec_point;
  ard_digitizer_model model (.clk(hclk), .rstn(hresetn), .ready(sample_ready), .rewind(rec_valid & rec_point.last),
    .slow(slow), .valid(sample_valid), .data(sample_data));
  ard_decimator #(.REC_DEPTH(8)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .trig, .sample_valid, .sample_data, .sample_ready, .rec_valid, .rec_point);
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdy;
    for (int i = 0; i < 50 && hreadyout !== 1'b1; i++) @(posedge hclk);
    if (hreadyout !== 1'b1) begin
      err_count++;
      results;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    rdy;
    r = hrdata;
  endtask
  task automatic stopped;
    for (int i = 0; i < 400; i++) begin
      bus(0, ARD_OFF_STATUS, 0);
      if (r[0] === 1'b0) return;
    end
    err_count++;
    results;
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (RSTV[i]) begin
      bus(0, RSTV[i][39:32], 0);
      ck("reset value", RSTV[i][31:0], r);
    end
    bus(1, 8'h20, 32'hffff_ffff);
    bus(0, 8'h20, 0);
    ck("unmapped", 0, r);
    bus(1, ARD_OFF_SPAN, 8);
    bus(1, ARD_OFF_POINTS, 4);
    bus(1, ARD_OFF_TARGET, 2);
    repeat (40) @(posedge hclk);
    bus(0, ARD_OFF_INTERVAL, 0);
    ck("interval", 4, r);
    $display("register test done");
    trig <= 1'b1;
    foreach (ROWS[i]) begin
      bus(1, ARD_OFF_CTRL, 32'({ROWS[i][42:40], 4'h3}));
      stopped;
      ck("status", {8'h0, ROWS[i][39:32], 12'h0, ROWS[i][42:40], 1'b0}, {r[31:16], 10'h0, r[5:0]});
      for (int k = 0; k < 4; k++) ck("point", 32'(ROWS[i][31 - 8 * k -: 8]), 32'(pts[k].value));
      $display("mode %0d test done", i);
    end
    slow <= 1'b1;
    bus(1, ARD_OFF_SPAN, 4);
    bus(1, ARD_OFF_CTRL, 32'h0000_0313);
    stopped;
    ck("interp status", 32'h0001_0010, {r[31:16], 10'h0, r[5:0]});
    bus(0, ARD_OFF_CTRL, 0);
    ck("mode kept", 32'h0000_0312, r);
    ck("interp point", 32'h0001_0001, 32'({pts[2].interp, pts[2].value}));
    ck("real point", 32'h0000_0002, 32'({pts[3].interp, pts[3].value}));
    $display("interpolation test done");
    bus(1, ARD_OFF_CTRL, 32'h0000_031b);
    stopped;
    ck("et status", 32'h0001_0020, {r[31:16], 10'h0, r[5:0]});
    ck("et point", 32'h0000_0004, 32'({pts[2].interp, pts[2].value}));
    bus(1, ARD_OFF_CTRL, 32'h0000_0317);
    stopped;
    ck("curve point", 32'h0001_0000, 32'({pts[2].interp, pts[2].value}));
    ck("curve real", 32'h0000_0002, 32'({pts[3].interp, pts[3].value}));
    $display("sampling variants test done");
    slow <= 1'b0;
    bus(1, ARD_OFF_CTRL, 32'h0000_0001);
    repeat (60) @(posedge hclk);
    bus(0, ARD_OFF_STATUS, 0);
    ck("running status", 32'h07d0_0001, r);
    hresetn <= 1'b0;
    @(posedge hclk);
    ck("reset data", 0, hrdata);
    ck("reset flags", 0, 32'({rec_valid, sample_ready}));
    hresetn <= 1'b1;
    @(posedge hclk);
    ck("flags after reset", 0, 32'({rec_valid, sample_ready}));
    bus(0, ARD_OFF_CTRL, 0);
    ck("ctrl after reset", ARD_CTRL_RST, r);
    bus(0, ARD_OFF_INFO, 0);
    ck("info", 32'h0249_000a, r);
    bus(1, ARD_OFF_TDIV, 100);
    bus(0, ARD_OFF_INFO, 0);
    ck("info fast", 32'h0248_000a, r);
    $display("reset test done");
    results;
  end
  initial begin
    #3000000;
    err_count++;
    results;
  end
endmodule
`default_nettype wire
